// ### hdl/seq_cfg.svh
`ifndef SEQ_CFG_SVH
`define SEQ_CFG_SVH
`define CLK_KHZ 40000
`define A_CTRL 8'h00
`define A_OC_CFG 8'h04
`define A_OT_CFG 8'h08
`define A_OT_LIMIT 8'h0C
`define A_TARGET 8'h10
`define A_OV_LIMIT 8'h14
`define A_STATUS 8'h18
`define CTRL_ON 0
`define CTRL_TRACK 1
`define CTRL_RATIO50 2
`define CTRL_LIM_REF 3
`define CTRL_FOLLOW 4
`define CTRL_SHARE 5
`define CTRL_STRAP 6
`define CTRL_OV_LATCH 7
`define CTRL_RST 8'h01
`define FCFG_RST 7'h18
`define OT_LIMIT_RST 8'h7D
`define OT_HYST 8'h0F
`define TARGET_RST 12'h0800
`define OV_LIMIT_RST 12'h0933
`define ST_PG 0
`define ST_OV 1
`define ST_OC 2
`define ST_OT 3
`define ST_RETRY_LSB 4
`define ST_STATE_LSB 8
`define T_TRK_ON_MS 5
`define T_TRK_OFF_MS 35
`define T_TRK_RAMP_MS 2
`define T_ON_DLY_MS 5
`define T_ON_RISE_MS 5
`define T_RETRY_MS 10
`define T_FLT_DLY_MS 1
`endif

// ### hdl/seq_pkg.sv
package seq_pkg;
  typedef enum logic [3:0] {
    S_OFF, S_DELAY, S_RAMP, S_HOLD_HI, S_RUN, S_TRACK, S_TRK_OFF,
    S_RETRY_WAIT, S_FAULT_HOLD, S_OV_HOLD, S_LATCHED
  } state_t;
  typedef enum logic [2:0] {
    RESP_SHUT, RESP_RETRY_INF, RESP_RETRY_N, RESP_DELAY_SHUT, RESP_IGNORE
  } resp_t;
  typedef struct packed {
    logic [3:0] retries;
    resp_t resp;
  } fault_cfg_t;
  typedef struct packed {
    logic ratio50;
    logic lim_ref;
    logic follow;
  } track_cfg_t;
  typedef struct packed {
    logic ot;
    logic oc;
    logic ov;
  } fault_flags_t;
endpackage

// ### hdl/startup_fault_tracking_sequencer.sv
// Operation
// - sample output before any ramp
// - below target: start at sample, ramp up
// - prebias ramp lasts exactly the ramp time
// - above target: start at sampled level
// - after soft-start: power good, ramp down
// - sample above ov limit: no start, ov fault
// - no prebias in sharing group with tracking
// - five selectable overcurrent responses
// - default overcurrent: shut down, re-enable on clear
// - shut down above programmable temperature limit
// - five selectable over-temperature responses
// - thermal retry waits, restarts below limit minus 15
// - default thermal: shut down, re-enable on clear
// - tracking uses the tracking reference input
// - strap tracking: fixed 5/35/2 ms timing
// - strap decodes ratio, limit and ramp behaviour
// - coincident tracking, target or reference limited
// - ratiometric 50 percent, output limited
// - ratiometric reference limited, capped by target
// - tracking ignores own soft-start delay
`timescale 1ns/10ps
`include "seq_cfg.svh"
module startup_fault_tracking_sequencer #(
  parameter int VW = 12,
  parameter int TURN_ON_DELAY_TIME = `T_ON_DLY_MS * `CLK_KHZ,
  parameter int TON_RISE = `T_ON_RISE_MS * `CLK_KHZ,
  parameter int RETRY_DLY = `T_RETRY_MS * `CLK_KHZ,
  parameter int FLT_DLY = `T_FLT_DLY_MS * `CLK_KHZ,
  parameter int TRK_ON = `T_TRK_ON_MS * `CLK_KHZ,
  parameter int TRK_OFF = `T_TRK_OFF_MS * `CLK_KHZ,
  parameter int TRK_RAMP = `T_TRK_RAMP_MS * `CLK_KHZ
)(
  input wire logic mclk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic enable_pin,
  input wire logic oc_fault_pin,
  input wire logic [2:0] tracking_strap_resistor,
  input wire logic [VW-1:0] vout_sample,
  input wire logic [VW-1:0] tracking_reference_input,
  input wire logic [7:0] temp_code,
  output logic [VW-1:0] working_target,
  output logic drivers_en,
  output logic ref_from_track,
  output logic power_good_output,
  output seq_pkg::fault_flags_t fault_flags
);
  import seq_pkg::*;

  if (VW < 4 || VW > 24 || TON_RISE <= (1 << VW))
    $error("ramp time must exceed the voltage code range");
  if (TURN_ON_DELAY_TIME < 1 || RETRY_DLY < 1 || FLT_DLY < 1 || TRK_ON < 1 || TRK_OFF < 1 ||
      TRK_RAMP < 1)
    $error("timing counts must be at least one cycle");

  function automatic logic hit(input logic [31:0] t, input int n);
    return t == 32'(n - 1);
  endfunction

  function automatic track_cfg_t strap_cfg(input logic [2:0] code);
    return '{ratio50: code[2], lim_ref: code[1], follow: code[0]};
  endfunction

  logic en_s1, en_s2, oc_s1, oc_s2;
  logic [2:0] strap_s1, strap_s2, strap_q;
  logic strap_done;
  logic [7:0] ctrl, ot_limit;
  fault_cfg_t oc_cfg, ot_cfg;
  logic [VW-1:0] target, ov_limit, samp, diff;
  state_t state;
  logic [31:0] timer, fcnt, acc;
  logic [3:0] retry_cnt;
  logic dn, cause_ot;

  // pins from outside the clock domain
  always_ff @(posedge mclk)
  begin
    en_s1 <= enable_pin;
    en_s2 <= en_s1;
    oc_s1 <= oc_fault_pin;
    oc_s2 <= oc_s1;
    strap_s1 <= tracking_strap_resistor;
    strap_s2 <= strap_s1;
  end

  // strap caught once after reset release
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      strap_done <= 1'b0;
      strap_q <= 3'h0;
    end
    else if (!strap_done)
    begin
      strap_done <= 1'b1;
      strap_q <= strap_s2;
    end
  end

  wire on = en_s2 & ctrl[`CTRL_ON];
  wire use_strap = ctrl[`CTRL_STRAP];
  wire track_en = ctrl[`CTRL_TRACK] | use_strap;
  // strap gives ratio, limit source and ramp behaviour
  wire track_cfg_t tcfg = use_strap ? strap_cfg(strap_q) :
    '{ctrl[`CTRL_RATIO50], ctrl[`CTRL_LIM_REF], ctrl[`CTRL_FOLLOW]};
  wire prebias_ok = !(ctrl[`CTRL_SHARE] && track_en);
  // tracking start delay replaces own soft-start delay
  wire [31:0] dly_last = track_en ? 32'(TRK_ON - 1) : 32'(TURN_ON_DELAY_TIME - 1);
  wire delay_done = timer == dly_last;
  wire on_st = state inside {S_RAMP, S_HOLD_HI, S_RUN, S_TRACK};
  wire ot_now = temp_code > ot_limit;
  wire [8:0] cool_sum = {1'b0, temp_code} + {1'b0, `OT_HYST};
  wire ot_cool = cool_sum < {1'b0, ot_limit};
  wire fault_now = ot_now | oc_s2;
  wire fault_cfg_t fcfg = ot_now ? ot_cfg : oc_cfg;
  wire still_bad = cause_ot ? !ot_cool : oc_s2;
  wire [31:0] sum = acc + 32'(diff);
  wire step = sum >= 32'(TON_RISE);

  // tracked reference with ratio and upper limit
  wire [VW-1:0] scaled = tcfg.ratio50 ? (tracking_reference_input >> 1) :
    tracking_reference_input;
  wire [VW-1:0] cap = tcfg.lim_ref ? (tcfg.ratio50 ? target : {VW{1'b1}}) :
    (tcfg.ratio50 ? (target >> 1) : target);
  wire [VW-1:0] trk_val = scaled < cap ? scaled : cap;
  wire trk_hold = !tcfg.follow && !power_good_output && trk_val < working_target;

  wire set_ov = state == S_DELAY && on && delay_done && vout_sample > ov_limit;
  wire set_oc = on_st && oc_s2;
  wire set_ot = on_st && ot_now;

  assign drivers_en = on_st || state == S_TRK_OFF;
  assign ref_from_track = track_en && (state == S_TRACK || state == S_TRK_OFF);

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      state <= S_OFF;
      timer <= 32'h0000_0000;
      fcnt <= 32'h0000_0000;
      acc <= 32'h0000_0000;
      samp <= '0;
      diff <= '0;
      working_target <= '0;
      power_good_output <= 1'b0;
      retry_cnt <= 4'h0;
      dn <= 1'b0;
      cause_ot <= 1'b0;
    end
    else
    begin
      timer <= timer + 32'h0000_0001;
      unique case (state)
        S_OFF:
        begin
          timer <= 32'h0000_0000;
          working_target <= '0;
          power_good_output <= 1'b0;
          retry_cnt <= 4'h0;
          if (on)
            state <= S_DELAY;
        end
        S_DELAY:
        begin
          if (delay_done)
          begin
            samp <= vout_sample;
            timer <= 32'h0000_0000;
            acc <= 32'h0000_0000;
            if (vout_sample > ov_limit)
              state <= S_OV_HOLD;
            else if (track_en)
            begin
              state <= S_TRACK;
              working_target <= prebias_ok ? vout_sample : '0;
            end
            else if (vout_sample > target)
            begin
              state <= S_HOLD_HI;
              working_target <= vout_sample;
            end
            else
            begin
              state <= S_RAMP;
              dn <= 1'b0;
              diff <= target - vout_sample;
              working_target <= vout_sample;
            end
          end
        end
        S_RAMP:
        begin
          // spread the distance evenly over the whole ramp time
          acc <= step ? sum - 32'(TON_RISE) : sum;
          if (step)
            working_target <= dn ? working_target - 1'b1 : working_target + 1'b1;
          if (hit(timer, TON_RISE))
          begin
            state <= S_RUN;
            power_good_output <= 1'b1;
            retry_cnt <= 4'h0;
          end
        end
        S_HOLD_HI:
        begin
          if (hit(timer, TON_RISE))
          begin
            state <= S_RAMP;
            dn <= 1'b1;
            diff <= working_target - target;
            acc <= 32'h0000_0000;
            timer <= 32'h0000_0000;
            power_good_output <= 1'b1;
          end
        end
        S_RUN:
          working_target <= target;
        S_TRACK:
        begin
          if (!trk_hold)
            working_target <= trk_val;
          if (power_good_output)
            timer <= timer;
          if (hit(timer, TRK_RAMP))
          begin
            power_good_output <= 1'b1;
            retry_cnt <= 4'h0;
          end
          if (!on)
          begin
            state <= S_TRK_OFF;
            timer <= 32'h0000_0000;
          end
        end
        S_TRK_OFF:
        begin
          // fall with the reference, give up after the off delay
          working_target <= trk_val;
          power_good_output <= 1'b0;
          if (hit(timer, TRK_OFF) || trk_val == '0)
            state <= S_OFF;
        end
        S_RETRY_WAIT:
        begin
          // overcurrent retries blindly, thermal waits for the cool-down margin
          if (hit(timer, RETRY_DLY))
          begin
            timer <= 32'h0000_0000;
            if (!cause_ot || ot_cool)
              state <= S_DELAY;
          end
        end
        S_FAULT_HOLD:
        begin
          timer <= 32'h0000_0000;
          if (!still_bad)
            state <= S_DELAY;
        end
        S_OV_HOLD:
        begin
          timer <= 32'h0000_0000;
          if (ctrl[`CTRL_OV_LATCH])
            state <= S_LATCHED;
          else if (vout_sample <= ov_limit)
            state <= S_DELAY;
        end
        S_LATCHED:
          timer <= 32'h0000_0000;
      endcase

      // fault response overrides the normal progression
      if (on_st && fault_now)
      begin
        fcnt <= fcnt + 32'h0000_0001;
        if (fcfg.resp != RESP_IGNORE && fcfg.resp != RESP_DELAY_SHUT)
        begin
          timer <= 32'h0000_0000;
          working_target <= '0;
          power_good_output <= 1'b0;
          cause_ot <= ot_now;
        end
        unique case (fcfg.resp)
          RESP_SHUT:
            state <= S_FAULT_HOLD;
          RESP_RETRY_INF:
            state <= S_RETRY_WAIT;
          RESP_RETRY_N:
          begin
            if (retry_cnt == fcfg.retries)
              state <= S_LATCHED;
            else
            begin
              retry_cnt <= retry_cnt + 4'h1;
              state <= S_RETRY_WAIT;
            end
          end
          RESP_DELAY_SHUT:
          begin
            if (hit(fcnt, FLT_DLY))
            begin
              state <= S_LATCHED;
              working_target <= '0;
              power_good_output <= 1'b0;
            end
          end
          RESP_IGNORE:
            fcnt <= fcnt;
        endcase
      end
      else
        fcnt <= 32'h0000_0000;

      if (!on && !(state inside {S_OFF, S_TRACK, S_TRK_OFF}))
      begin
        state <= S_OFF;
        power_good_output <= 1'b0;
      end
    end
  end

  // register port
  wire wr_ctrl = reg_wr && reg_addr == `A_CTRL;
  wire wr_status = reg_wr && reg_addr == `A_STATUS;
  wire [31:0] status_word = 32'({4'(state), retry_cnt, fault_flags.ot, fault_flags.oc,
    fault_flags.ov, power_good_output});
  wire [31:0] rd_mux =
    reg_addr == `A_CTRL ? 32'(ctrl) :
    reg_addr == `A_OC_CFG ? 32'(oc_cfg) :
    reg_addr == `A_OT_CFG ? 32'(ot_cfg) :
    reg_addr == `A_OT_LIMIT ? 32'(ot_limit) :
    reg_addr == `A_TARGET ? 32'(target) :
    reg_addr == `A_OV_LIMIT ? 32'(ov_limit) :
    reg_addr == `A_STATUS ? status_word : 32'h0000_0000;

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      ctrl <= `CTRL_RST;
      oc_cfg <= `FCFG_RST;
      ot_cfg <= `FCFG_RST;
      ot_limit <= `OT_LIMIT_RST;
      target <= VW'(`TARGET_RST);
      ov_limit <= VW'(`OV_LIMIT_RST);
      reg_rdata <= 32'h0000_0000;
    end
    else
    begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
      if (wr_ctrl)
        ctrl <= reg_wdata[7:0];
      if (reg_wr && reg_addr == `A_OC_CFG)
        oc_cfg <= fault_cfg_t'(reg_wdata[6:0]);
      if (reg_wr && reg_addr == `A_OT_CFG)
        ot_cfg <= fault_cfg_t'(reg_wdata[6:0]);
      if (reg_wr && reg_addr == `A_OT_LIMIT)
        ot_limit <= reg_wdata[7:0];
      if (reg_wr && reg_addr == `A_TARGET)
        target <= reg_wdata[VW-1:0];
      if (reg_wr && reg_addr == `A_OV_LIMIT)
        ov_limit <= reg_wdata[VW-1:0];
    end
  end

  // sticky flags, write one to clear, a new event wins
  always_ff @(posedge mclk)
  begin
    if (srst)
      fault_flags <= '0;
    else
    begin
      fault_flags.ov <= set_ov | (fault_flags.ov & ~(wr_status & reg_wdata[`ST_OV]));
      fault_flags.oc <= set_oc | (fault_flags.oc & ~(wr_status & reg_wdata[`ST_OC]));
      fault_flags.ot <= set_ot | (fault_flags.ot & ~(wr_status & reg_wdata[`ST_OT]));
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  property p_sample;
    $past(state) == S_DELAY && state inside {S_RAMP, S_HOLD_HI, S_TRACK, S_OV_HOLD}
      |-> samp == $past(vout_sample);
  endproperty
  a_sample: assert property (p_sample) else $error("output not sampled at delay end");

  property p_low_start;
    $past(state) == S_DELAY && state == S_RAMP |-> working_target == samp && drivers_en;
  endproperty
  a_low_start: assert property (p_low_start) else $error("ramp not started at sample");

  property p_ramp_end;
    state == S_RAMP && hit(timer, TON_RISE) && $stable(target) && on && !fault_now
      |=> working_target == $past(target) && state == S_RUN;
  endproperty
  a_ramp_end: assert property (p_ramp_end) else $error("target not met at ramp end");

  property p_high_hold;
    state == S_HOLD_HI |-> drivers_en && working_target == samp && !power_good_output;
  endproperty
  a_high_hold: assert property (p_high_hold) else $error("high prebias not held");

  property p_high_pg;
    state == S_HOLD_HI && hit(timer, TON_RISE) && on && !fault_now
      |=> power_good_output && state == S_RAMP && dn;
  endproperty
  a_high_pg: assert property (p_high_pg) else $error("no power good after soft-start");

  property p_ov;
    state == S_OV_HOLD |-> !drivers_en && !power_good_output && fault_flags.ov;
  endproperty
  a_ov: assert property (p_ov) else $error("started despite overvoltage prebias");

  property p_share;
    $past(state) == S_DELAY && state == S_TRACK && !$past(prebias_ok) |-> working_target == '0;
  endproperty
  a_share: assert property (p_share) else $error("prebias used in sharing group");

  property p_shut;
    on_st && fault_now && fcfg.resp == RESP_SHUT && on |=> state == S_FAULT_HOLD ##1 !drivers_en;
  endproperty
  a_shut: assert property (p_shut) else $error("fault did not shut down");

  property p_retry_cnt;
    state == S_RETRY_WAIT |-> (cause_ot ? ot_cfg.resp : oc_cfg.resp) == RESP_RETRY_INF ||
      (retry_cnt != 4'h0 && retry_cnt <= (cause_ot ? ot_cfg.retries : oc_cfg.retries));
  endproperty
  a_retry_cnt: assert property (p_retry_cnt) else $error("retry wait without retry mode");

  c_low_ramp: cover property (state == S_RAMP && !dn ##1 state == S_RUN);
  c_high_ramp: cover property (state == S_HOLD_HI ##1 state == S_RAMP);
  c_track_pg: cover property (state == S_TRACK && power_good_output);
  c_retry: cover property (state == S_RETRY_WAIT ##1 state == S_DELAY);
endmodule

// ### testbench/far_side_model.sv
`timescale 1ns/10ps
module far_side_model #(
  parameter int REF_DLY = 40,
  parameter logic [11:0] REF_TOP = 12'h0c00
)(
  input wire logic mclk,
  input wire logic drivers_en,
  input wire logic [11:0] working_target,
  input wire logic [11:0] prebias,
  input wire logic ref_go,
  output logic [11:0] vout_sample,
  output logic [11:0] tracking_reference_input
);
  int dly = 0;
  initial vout_sample = 12'h0000;
  initial tracking_reference_input = 12'h0000;
  // driven output settles on target, undriven output shows the external prebias
  always @(posedge mclk)
  begin
    vout_sample <= drivers_en ? working_target : prebias;
    dly <= ref_go ? dly + 1 : 0;
    // untracked reference rail, ramps only after its own start delay
    if (!ref_go)
      tracking_reference_input <= 12'h0000;
    else if (dly >= REF_DLY && tracking_reference_input < REF_TOP)
      tracking_reference_input <= tracking_reference_input + 12'h0004;
  end
endmodule

// ### testbench/startup_fault_tracking_sequencer_tb.sv
`timescale 1ns/10ps
`include "seq_cfg.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, (e), (g)); end end
module startup_fault_tracking_sequencer_tb;
  import seq_pkg::*;
  localparam int RISE = 5000;
  localparam int RETRY = 40;
  localparam int FDLY = 20;
  logic mclk;
  logic srst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic enable_pin = 1'b0;
  logic oc_fault_pin = 1'b0;
  logic ref_go = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] temp_code = 8'h19;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [11:0] prebias = 12'h0400;
  logic [2:0] strap = 3'h5;
  logic [31:0] reg_rdata;
  logic [31:0] rd_val;
  logic [11:0] vout_sample;
  logic [11:0] tracking_reference_input;
  logic [11:0] working_target;
  logic drivers_en;
  logic ref_from_track;
  logic power_good_output;
  fault_flags_t fault_flags;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  int n = 0;
  logic [7:0] reg_adr [7] = '{`A_CTRL, `A_OC_CFG, `A_OT_CFG, `A_OT_LIMIT, `A_TARGET,
    `A_OV_LIMIT, 8'h1c};
  logic [31:0] reg_rst [7] = '{32'h0000_0001, 32'h0000_0018, 32'h0000_0018,
    32'h0000_007d, 32'h0000_0800, 32'h0000_0933, 32'h0000_0000};
  logic [31:0] oc_cfg [3] = '{32'h0000_0004, 32'h0000_0003, 32'h0000_000a};
  logic [31:0] trk_ctrl [5] = '{32'h0000_0003, 32'h0000_000b, 32'h0000_0007,
    32'h0000_000f, 32'h0000_0041};
  logic [11:0] trk_exp [5] = '{12'h0800, 12'h0c00, 12'h0400, 12'h0600, 12'h0400};

  startup_fault_tracking_sequencer #(
    .TURN_ON_DELAY_TIME(20), .TON_RISE(RISE), .RETRY_DLY(RETRY), .FLT_DLY(FDLY),
    .TRK_ON(20), .TRK_OFF(60), .TRK_RAMP(30)
  ) dut (
    .mclk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .enable_pin,
    .oc_fault_pin, .tracking_strap_resistor(strap), .vout_sample, .tracking_reference_input,
    .temp_code, .working_target, .drivers_en, .ref_from_track, .power_good_output,
    .fault_flags
  );

  far_side_model far_side (
    .mclk, .drivers_en, .working_target, .prebias, .ref_go, .vout_sample,
    .tracking_reference_input
  );

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task stop_test;
    if (error_cnt == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      error_cnt++;
      stop_test();
    end
  end

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task rd(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask

  // bounded wait on drivers_en or power good, n counts the edges
  task wait_on(input logic pg_sel, input logic lvl, input int lim);
    n = 0;
    do
    begin
      @(posedge mclk);
      #1 n++;
    end
    while (((pg_sel ? power_good_output : drivers_en) !== lvl) && n < lim);
  endtask

  // full power cycle with a new prebias and control word
  task restart(input logic [11:0] pb, input logic [31:0] ctrl);
    @(posedge mclk) enable_pin <= 1'b0;
    repeat (80) @(posedge mclk);
    prebias <= pb;
    wr(`A_CTRL, ctrl);
    wr(`A_STATUS, 32'h0000_000e);
    @(posedge mclk) enable_pin <= 1'b1;
    wait_on(1'b0, 1'b1, 200);
  endtask

  initial
  begin
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    wr(8'h1c, 32'hffff_ffff);
    for (int i = 0; i < 7; i++)
    begin
      rd(reg_adr[i]);
      `CHK("reset value", reg_rst[i], rd_val)
    end
    restart(12'h0400, 32'h0000_0001);
    `CHK("start target", 12'h0400, working_target)
    wait_on(1'b1, 1'b1, RISE + 100);
    `CHK("ramp cycles", RISE, n)
    `CHK("final target", 12'h0800, working_target)
    @(posedge mclk) oc_fault_pin <= 1'b1;
    wait_on(1'b0, 1'b0, 10);
    `CHK("oc shutdown", 1'b0, drivers_en)
    `CHK("oc flag", 1'b1, fault_flags.oc)
    @(posedge mclk) oc_fault_pin <= 1'b0;
    wait_on(1'b0, 1'b1, 100);
    `CHK("oc re-enable", 1'b1, drivers_en)
    wr(`A_OT_CFG, 32'h0000_0019);
    @(posedge mclk) temp_code <= 8'h82;
    wait_on(1'b0, 1'b0, 10);
    rd(`A_STATUS);
    `CHK("ot flag", 1'b1, rd_val[3])
    // exactly at limit minus hysteresis: must stay off
    @(posedge mclk) temp_code <= 8'h6e;
    repeat (3 * RETRY) @(posedge mclk);
    `CHK("ot hysteresis", 1'b0, drivers_en)
    @(posedge mclk) temp_code <= 8'h6d;
    wait_on(1'b0, 1'b1, RETRY + 60);
    `CHK("ot restart", 1'b1, drivers_en)
    wr(`A_OT_CFG, 32'h0000_0018);
    for (int i = 0; i < 3; i++)
    begin
      wr(`A_OC_CFG, oc_cfg[i]);
      restart(12'h0400, 32'h0000_0001);
      @(posedge mclk) oc_fault_pin <= 1'b1;
      repeat (FDLY - 4) @(posedge mclk);
      #1;
      `CHK("oc mode early", (i != 2), drivers_en)
      repeat (300) @(posedge mclk);
      #1;
      `CHK("oc mode late", (i == 0), drivers_en)
      rd(`A_STATUS);
      `CHK("oc mode state", (i == 0) ? 4'h2 : 4'ha, rd_val[11:8])
      @(posedge mclk) oc_fault_pin <= 1'b0;
    end
    wr(`A_OC_CFG, 32'h0000_0018);
    restart(12'h0900, 32'h0000_0001);
    `CHK("high start", 12'h0900, working_target)
    wait_on(1'b1, 1'b1, RISE + 100);
    `CHK("hold cycles", RISE, n)
    repeat (RISE + 10) @(posedge mclk);
    `CHK("ramp down", 12'h0800, working_target)
    restart(12'h0a00, 32'h0000_0001);
    `CHK("ov no start", 1'b0, drivers_en)
    rd(`A_STATUS);
    `CHK("ov flag", 1'b1, rd_val[1])
    for (int i = 0; i < 5; i++)
    begin
      restart(12'h0000, trk_ctrl[i]);
      @(posedge mclk) ref_go <= 1'b1;
      `CHK("track ref", 1'b1, ref_from_track)
      repeat (1000) @(posedge mclk);
      `CHK("track level", trk_exp[i], working_target)
      @(posedge mclk) ref_go <= 1'b0;
    end
    stop_test();
  end
endmodule
